//--- bench/clkg_osc_model.sv
// Behavioural model of the crystals or external clock sources at the oscillator pins.
`timescale 1ns/1ps
`default_nettype none
module clkg_osc_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire clkg_pkg::clkg_osc_ctrl_t osc_ctrl,
  input wire logic [3:0] start_cycles,
  output logic main_clk_stable,
  output logic sub_clk_stable
);
  logic [3:0] main_cnt;
  logic [3:0] sub_cnt;
  logic main_live;
  logic sub_live;
  // A source only oscillates with its pins out of port mode and its halt bit clear.
  assign main_live = (osc_ctrl.main_mode != clkg_pkg::PIN_PORT) && osc_ctrl.main_run;
  assign sub_live = (osc_ctrl.sub_mode != clkg_pkg::PIN_PORT) && osc_ctrl.sub_run;
  // One start-up delay, shared by both sources, lets the bench test both prompt and slow sources.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_cnt <= 4'h0;
    end else if (!main_live) begin
      main_cnt <= 4'h0;
    end else if (main_cnt != start_cycles) begin
      main_cnt <= main_cnt + 4'h1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sub_cnt <= 4'h0;
    end else if (!sub_live) begin
      sub_cnt <= 4'h0;
    end else if (sub_cnt != start_cycles) begin
      sub_cnt <= sub_cnt + 4'h1;
    end
  end
  assign main_clk_stable = main_live && (main_cnt == start_cycles);
  assign sub_clk_stable = sub_live && (sub_cnt == start_cycles);
endmodule : clkg_osc_model
`default_nettype wire

//--- bench/test_clock_generator_control.sv
// Self-checking testbench for the clock generator control block.
`timescale 1ns/1ps
`default_nettype none
module test_clock_generator_control;
  localparam logic [31:0] A_PIN = {28'h0, clkg_pkg::ADDR_PIN_CFG};
  localparam logic [31:0] A_RUN = {28'h0, clkg_pkg::ADDR_RUN_CTL};
  localparam logic [31:0] A_SEL = {28'h0, clkg_pkg::ADDR_SYS_SEL};
  localparam logic [31:0] A_SUP = {28'h0, clkg_pkg::ADDR_SUPPLY};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic main_clk_stable;
  logic sub_clk_stable;
  logic standby_active = 1'b0;
  logic [3:0] start_cycles = 4'h2;
  clkg_pkg::clkg_osc_ctrl_t osc_ctrl;
  logic cpu_clock_from_sub;
  logic main_clock_from_ext;
  logic periph_sub_clock_en;
  logic timer_clock_from_slow;
  logic [31:0] rd;
  logic [1:0] d;
  logic [1:0] ed;
  logic [1:0] mode_of [4] = '{2'h0, 2'h1, 2'h0, 2'h2};
  int failures = 0;
  int num_checks = 0;

  always #5 hclk = ~hclk;

  clkg_top uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .main_clk_stable(main_clk_stable), .sub_clk_stable(sub_clk_stable),
    .standby_active(standby_active), .osc_ctrl(osc_ctrl),
    .cpu_clock_from_sub(cpu_clock_from_sub), .main_clock_from_ext(main_clock_from_ext),
    .periph_sub_clock_en(periph_sub_clock_en), .timer_clock_from_slow(timer_clock_from_slow)
  );

  clkg_osc_model osc (
    .hclk(hclk), .hresetn(hresetn), .osc_ctrl(osc_ctrl), .start_cycles(start_cycles),
    .main_clk_stable(main_clk_stable), .sub_clk_stable(sub_clk_stable)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One single AHB-Lite transfer; the master never assumes a wait-state count.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= clkg_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [7:0] v);
    bus(1'b1, a, {24'h0, v});
  endtask : wr

  task automatic rchk(input string what, input logic [31:0] a, input logic [7:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, rd, {24'h0, exp});
  endtask : rchk

  task automatic poll(input logic [7:0] m, input logic [7:0] want);
    for (int i = 0; i < 40; i++) begin
      bus(1'b0, A_SEL, 32'h0);
      if ((rd[7:0] & m) === want) break;
    end
  endtask : poll

  task automatic test_done;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  initial begin
    #100000;
    failures++;
    test_done();
  end

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk("pin_rst", A_PIN, clkg_pkg::PIN_CFG_RST);
    rchk("run_rst", A_RUN, clkg_pkg::RUN_CTL_RST);
    rchk("sel_rst", A_SEL, clkg_pkg::SYS_SEL_RST);
    rchk("sup_rst", A_SUP, clkg_pkg::SUPPLY_RST);
    // Every pin code; the last pass writes the forbidden drive code, which must not take.
    for (int c = 0; c < 4; c++) begin
      d = 2'(c);
      ed = (c == 3) ? 2'h2 : d;
      wr(A_PIN, {2'(c), 2'(c), 1'b0, d, c[0]});
      rchk("pin_cfg", A_PIN, {2'(c), 2'(c), 1'b0, ed, c[0]});
      repeat (2) @(posedge hclk);
      check("main_mode", 32'(osc_ctrl.main_mode), 32'(mode_of[c]));
      check("sub_mode", 32'(osc_ctrl.sub_mode), 32'(mode_of[c]));
      check("sub_drive", 32'(osc_ctrl.sub_drive), 32'(ed));
      check("freq_range", 32'(osc_ctrl.main_freq_range), 32'(c[0]));
    end
    wr(A_RUN, 8'hFF);
    rchk("run_mask", A_RUN, 8'hC1);
    check("fast_off", 32'(osc_ctrl.fast_run), 32'h0);
    wr(A_RUN, 8'hC0);
    rchk("run_halt", A_RUN, 8'hC0);
    check("main_off", 32'(osc_ctrl.main_run), 32'h0);
    check("sub_off", 32'(osc_ctrl.sub_run), 32'h0);
    wr(A_RUN, 8'h00);
    rchk("run_go", A_RUN, 8'h00);
    check("main_on", 32'(osc_ctrl.main_run), 32'h1);
    check("sub_on", 32'(osc_ctrl.sub_run), 32'h1);
    check("fast_on", 32'(osc_ctrl.fast_run), 32'h1);
    wr(A_SEL, 8'hFF);
    rchk("sel_early", A_SEL, 8'h50);
    wr(A_SEL, 8'h10);
    poll(8'hA0, 8'h20);
    check("main_stat", rd, 32'h30);
    check("main_ext", 32'(main_clock_from_ext), 32'h1);
    // A slow subsystem external clock: the status must wait for it.
    wr(A_RUN, 8'h40);
    start_cycles <= 4'hC;
    wr(A_SEL, 8'h50);
    wr(A_RUN, 8'h00);
    rchk("cpu_early", A_SEL, 8'h70);
    poll(8'h80, 8'h80);
    check("cpu_stat", rd, 32'hF0);
    check("cpu_sub", 32'(cpu_clock_from_sub), 32'h1);
    standby_active <= 1'b1;
    wr(A_SUP, 8'h80);
    repeat (2) @(posedge hclk);
    check("gate_on", 32'(periph_sub_clock_en), 32'h0);
    standby_active <= 1'b0;
    repeat (2) @(posedge hclk);
    check("gate_awake", 32'(periph_sub_clock_en), 32'h1);
    wr(A_SUP, 8'hFF);
    rchk("sup_mask", A_SUP, 8'h90);
    check("timer_slow", 32'(timer_clock_from_slow), 32'h1);
    standby_active <= 1'b1;
    wr(A_SUP, 8'h00);
    repeat (2) @(posedge hclk);
    check("gate_off", 32'(periph_sub_clock_en), 32'h1);
    check("timer_sub", 32'(timer_clock_from_slow), 32'h0);
    standby_active <= 1'b0;
    wr(A_SEL, 8'h10);
    poll(8'h80, 8'h00);
    check("cpu_main", rd, 32'h30);
    wr(A_SEL, 8'h00);
    poll(8'h20, 8'h00);
    check("main_fast", rd, 32'h00);
    // A halted main oscillator never becomes ready, so the switch must not complete.
    wr(A_RUN, 8'h80);
    wr(A_SEL, 8'h10);
    repeat (30) @(posedge hclk);
    rchk("switch_held", A_SEL, 8'h10);
    check("main_int", 32'(main_clock_from_ext), 32'h0);
    wr(32'h10, 8'hFF);
    rchk("unmapped", 32'h10, 8'h00);
    rchk("pin_kept", A_PIN, 8'hF5);
    test_done();
  end
endmodule : test_clock_generator_control
`default_nettype wire

//--- logic/clkg_pkg.sv
// Constants, types and helpers shared by the clock generator control block.
`default_nettype none
package clkg_pkg;
  // Register byte addresses on the AHB-Lite bus, low address bits only.
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_PIN_CFG = 4'h0;
  localparam logic [3:0] ADDR_RUN_CTL = 4'h4;
  localparam logic [3:0] ADDR_SYS_SEL = 4'h8;
  localparam logic [3:0] ADDR_SUPPLY = 4'hC;
  // Field positions.
  localparam int MAIN_EXT_BIT = 7;
  localparam int MAIN_OSC_BIT = 6;
  localparam int SUB_EXT_BIT = 5;
  localparam int SUB_OSC_BIT = 4;
  localparam int DRIVE_HI_BIT = 2;
  localparam int DRIVE_LO_BIT = 1;
  localparam int RANGE_BIT = 0;
  localparam int MAIN_HALT_BIT = 7;
  localparam int SUB_HALT_BIT = 6;
  localparam int FAST_HALT_BIT = 0;
  localparam int CPU_STAT_BIT = 7;
  localparam int CPU_SEL_BIT = 6;
  localparam int MAIN_STAT_BIT = 5;
  localparam int MAIN_SEL_BIT = 4;
  localparam int SUB_GATE_BIT = 7;
  localparam int TIMER_SEL_BIT = 4;
  // Writable bits of each register; all others read as zero, except the CPU and main status bits of the system select register.
  localparam logic [7:0] PIN_CFG_MASK = 8'hF7;
  localparam logic [7:0] RUN_CTL_MASK = 8'hC1;
  localparam logic [7:0] SYS_SEL_MASK = 8'h50;
  localparam logic [7:0] SUPPLY_MASK = 8'h90;
  // Reset values.
  localparam logic [7:0] PIN_CFG_RST = 8'h00;
  localparam logic [7:0] RUN_CTL_RST = 8'hC0;
  localparam logic [7:0] SYS_SEL_RST = 8'h00;
  localparam logic [7:0] SUPPLY_RST = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // Settling time of the glitch-free switch, and its length in cycles.
  localparam int CLK_PERIOD_NS = 10;
  localparam int SWITCH_SETTLE_NS = 40;
  localparam logic [2:0] SWITCH_CYCLES =
    3'((SWITCH_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    DRIVE_LOW_POWER = 2'h0,
    DRIVE_NORMAL = 2'h1,
    DRIVE_ULTRA_LOW = 2'h2,
    DRIVE_PROHIBITED = 2'h3
  } clkg_drive_t;

  typedef enum logic [1:0] {
    PIN_PORT = 2'h0,
    PIN_CRYSTAL = 2'h1,
    PIN_EXTERNAL = 2'h2
  } clkg_pin_mode_t;

  // Control bundle towards the oscillator pads and analog cells.
  typedef struct packed {
    clkg_pin_mode_t main_mode;
    clkg_pin_mode_t sub_mode;
    logic main_run;
    logic sub_run;
    logic fast_run;
    clkg_drive_t sub_drive;
    logic main_freq_range;
  } clkg_osc_ctrl_t;

  // Both 00 and 10 leave the pins as plain inputs.
  function automatic clkg_pin_mode_t pin_mode(input logic ext_sel, input logic osc_sel);
    if (!osc_sel) begin
      return PIN_PORT;
    end else if (ext_sel) begin
      return PIN_EXTERNAL;
    end
    return PIN_CRYSTAL;
  endfunction : pin_mode
endpackage : clkg_pkg
`default_nettype wire

//--- logic/clkg_top.sv
// Clock generator control: AHB-Lite registers, oscillator control, glitch-free source switch.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Main pin field: 00/10 input port, 01 crystal, 11 external clock input.
// - Subsystem pin field: 00/10 input port, 01 low-frequency crystal, 11 external clock.
// - Subsystem drive: 00 low-power, 01 normal, 10 ultra-low; 11 prohibited.
// - Main frequency range bit: 0 for 1-10 MHz, 1 for 10-20 MHz.
// - Main halt bit stops crystal or ignores external clock; no effect in port mode.
// - Subsystem halt bit stops crystal or invalidates external clock; port mode stays port.
// - Internal fast oscillator runs when its halt bit is 0, stops when 1.
// - CPU select bit: 0 main system clock, 1 subsystem clock.
// - Read-only CPU status bit reports the source actually driving the CPU clock.
// - Main source select: 0 internal fast oscillator, 1 external fast clock.
// - Read-only main status bit reports the source actually feeding the main clock.
// - In standby on subsystem clock, gate bit 1 stops subsystem clock except timers.
// - Timer count clock: 0 subsystem clock, 1 internal slow oscillator.
module clkg_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic main_clk_stable,
  input wire logic sub_clk_stable,
  input wire logic standby_active,
  output clkg_pkg::clkg_osc_ctrl_t osc_ctrl,
  output logic cpu_clock_from_sub,
  output logic main_clock_from_ext,
  output logic periph_sub_clock_en,
  output logic timer_clock_from_slow
);
  typedef enum {SW_IDLE, SW_SETTLE} clkg_sw_state_t;

  logic [7:0] pin_cfg_reg;
  logic [7:0] pin_cfg_next;
  logic [7:0] run_ctl_reg;
  logic [7:0] run_ctl_next;
  logic [7:0] sys_sel_reg;
  logic [7:0] sys_sel_next;
  logic [7:0] supply_reg;
  logic [7:0] supply_next;
  logic cpu_stat_reg;
  logic main_stat_reg;
  logic wr_pend_reg;
  logic [3:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic hresp_reg;
  logic [7:0] rd_value;
  logic addr_accept;
  clkg_sw_state_t sw_state_reg;
  logic sw_is_main_reg;
  logic [2:0] sw_count_reg;
  logic main_ext_ready;
  logic sub_ready;
  logic fast_ready;
  logic main_want;
  logic cpu_want;
  logic main_target_ok;
  logic cpu_target_ok;
  clkg_pkg::clkg_osc_ctrl_t osc_ctrl_reg;
  logic periph_sub_en_reg;
  logic timer_slow_reg;

  assign hreadyout = hreadyout_reg;
  assign hrdata = hrdata_reg;
  // The response is always OKAY, but it still leaves a flip-flop like every other output.
  assign hresp = hresp_reg;
  assign osc_ctrl = osc_ctrl_reg;
  assign cpu_clock_from_sub = cpu_stat_reg;
  assign main_clock_from_ext = main_stat_reg;
  assign periph_sub_clock_en = periph_sub_en_reg;
  assign timer_clock_from_slow = timer_slow_reg;

  // Only full-word NONSEQ transfers are used; other sizes are taken as words.
  assign addr_accept = hsel && hready && (htrans == clkg_pkg::HTRANS_NONSEQ);

  // Register values after the write of the data phase now ending.
  always_comb begin
    pin_cfg_next = pin_cfg_reg;
    run_ctl_next = run_ctl_reg;
    sys_sel_next = sys_sel_reg;
    supply_next = supply_reg;
    if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        clkg_pkg::ADDR_PIN_CFG: begin
          pin_cfg_next = hwdata[7:0] & clkg_pkg::PIN_CFG_MASK;
          // A prohibited drive code is refused so the amplifier never sees it.
          if (hwdata[clkg_pkg::DRIVE_HI_BIT:clkg_pkg::DRIVE_LO_BIT] == 2'h3) begin
            pin_cfg_next[clkg_pkg::DRIVE_HI_BIT:clkg_pkg::DRIVE_LO_BIT] =
              pin_cfg_reg[clkg_pkg::DRIVE_HI_BIT:clkg_pkg::DRIVE_LO_BIT];
          end
        end
        clkg_pkg::ADDR_RUN_CTL: run_ctl_next = hwdata[7:0] & clkg_pkg::RUN_CTL_MASK;
        clkg_pkg::ADDR_SYS_SEL: sys_sel_next = hwdata[7:0] & clkg_pkg::SYS_SEL_MASK;
        clkg_pkg::ADDR_SUPPLY: supply_next = hwdata[7:0] & clkg_pkg::SUPPLY_MASK;
        default: ;
      endcase
    end
  end

  // Read mux forwards a write finishing in the same cycle, so back-to-back
  // write then read of one register returns the new value.
  always_comb begin
    rd_value = 8'h00;
    unique case (haddr[clkg_pkg::ADDR_W-1:0])
      clkg_pkg::ADDR_PIN_CFG: rd_value = pin_cfg_next;
      clkg_pkg::ADDR_RUN_CTL: rd_value = run_ctl_next;
      clkg_pkg::ADDR_SYS_SEL: begin
        rd_value = sys_sel_next;
        rd_value[clkg_pkg::CPU_STAT_BIT] = cpu_stat_reg;
        rd_value[clkg_pkg::MAIN_STAT_BIT] = main_stat_reg;
      end
      clkg_pkg::ADDR_SUPPLY: rd_value = supply_next;
      default: rd_value = 8'h00;
    endcase
    if (haddr[31:clkg_pkg::ADDR_W] != 28'h0000000) begin
      rd_value = 8'h00;
    end
  end

  // Bus slave: zero wait states, unmapped addresses read zero and ignore writes.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 4'h0;
      hrdata_reg <= 32'h00000000;
      hreadyout_reg <= 1'b0;
      hresp_reg <= 1'b0;
    end else begin
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
      wr_pend_reg <= addr_accept && hwrite && (haddr[31:clkg_pkg::ADDR_W] == 28'h0000000);
      if (addr_accept) begin
        wr_addr_reg <= haddr[clkg_pkg::ADDR_W-1:0];
      end
      if (addr_accept && !hwrite) begin
        hrdata_reg <= {24'h000000, rd_value};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_cfg_reg <= clkg_pkg::PIN_CFG_RST;
      run_ctl_reg <= clkg_pkg::RUN_CTL_RST;
      sys_sel_reg <= clkg_pkg::SYS_SEL_RST;
      supply_reg <= clkg_pkg::SUPPLY_RST;
    end else begin
      pin_cfg_reg <= pin_cfg_next;
      run_ctl_reg <= run_ctl_next;
      sys_sel_reg <= sys_sel_next;
      supply_reg <= supply_next;
    end
  end

  // Source readiness: a pin source is usable only when its pins are in a clock
  // mode, it is not halted and the analog side reports it stable; the fast oscillator needs only its halt bit clear.
  assign main_ext_ready = (osc_ctrl_reg.main_mode != clkg_pkg::PIN_PORT)
    && !run_ctl_reg[clkg_pkg::MAIN_HALT_BIT] && main_clk_stable;
  assign sub_ready = (osc_ctrl_reg.sub_mode != clkg_pkg::PIN_PORT)
    && !run_ctl_reg[clkg_pkg::SUB_HALT_BIT] && sub_clk_stable;
  assign fast_ready = !run_ctl_reg[clkg_pkg::FAST_HALT_BIT];
  assign main_want = sys_sel_reg[clkg_pkg::MAIN_SEL_BIT];
  assign cpu_want = sys_sel_reg[clkg_pkg::CPU_SEL_BIT];
  assign main_target_ok = main_want ? main_ext_ready : fast_ready;
  assign cpu_target_ok = cpu_want ? sub_ready : 1'b1;

  // Switch sequencer. A switch waits for the target source, then holds for
  // the settle time before the status flips, so software polling status
  // never sees the new source before the mux has really moved over. The main
  // mux is served first because the CPU may be running from it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_state_reg <= SW_IDLE;
      sw_is_main_reg <= 1'b0;
      sw_count_reg <= 3'h0;
    end else begin
      unique case (sw_state_reg)
        SW_IDLE: begin
          if ((main_want != main_stat_reg) && main_target_ok) begin
            sw_state_reg <= SW_SETTLE;
            sw_is_main_reg <= 1'b1;
            sw_count_reg <= clkg_pkg::SWITCH_CYCLES - 3'h1;
          end else if ((cpu_want != cpu_stat_reg) && cpu_target_ok) begin
            sw_state_reg <= SW_SETTLE;
            sw_is_main_reg <= 1'b0;
            sw_count_reg <= clkg_pkg::SWITCH_CYCLES - 3'h1;
          end
        end
        SW_SETTLE: begin
          // Abandon the switch if the select is taken back mid-way.
          if (sw_is_main_reg ? (main_want == main_stat_reg) : (cpu_want == cpu_stat_reg)) begin
            sw_state_reg <= SW_IDLE;
          end else if (sw_count_reg == 3'h0) begin
            sw_state_reg <= SW_IDLE;
          end else begin
            sw_count_reg <= sw_count_reg - 3'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_stat_reg <= 1'b0;
      main_stat_reg <= 1'b0;
    end else if ((sw_state_reg == SW_SETTLE) && (sw_count_reg == 3'h0)) begin
      if (sw_is_main_reg && (main_want != main_stat_reg)) begin
        main_stat_reg <= main_want;
      end
      if (!sw_is_main_reg && (cpu_want != cpu_stat_reg)) begin
        cpu_stat_reg <= cpu_want;
      end
    end
  end

  // Oscillator and pad controls.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_ctrl_reg <= '0;
    end else begin
      osc_ctrl_reg.main_mode <= clkg_pkg::pin_mode(pin_cfg_reg[clkg_pkg::MAIN_EXT_BIT],
        pin_cfg_reg[clkg_pkg::MAIN_OSC_BIT]);
      osc_ctrl_reg.sub_mode <= clkg_pkg::pin_mode(pin_cfg_reg[clkg_pkg::SUB_EXT_BIT],
        pin_cfg_reg[clkg_pkg::SUB_OSC_BIT]);
      osc_ctrl_reg.main_run <= pin_cfg_reg[clkg_pkg::MAIN_OSC_BIT]
        && !run_ctl_reg[clkg_pkg::MAIN_HALT_BIT];
      osc_ctrl_reg.sub_run <= pin_cfg_reg[clkg_pkg::SUB_OSC_BIT]
        && !run_ctl_reg[clkg_pkg::SUB_HALT_BIT];
      osc_ctrl_reg.fast_run <= !run_ctl_reg[clkg_pkg::FAST_HALT_BIT];
      osc_ctrl_reg.sub_drive <= clkg_pkg::clkg_drive_t'(
        pin_cfg_reg[clkg_pkg::DRIVE_HI_BIT:clkg_pkg::DRIVE_LO_BIT]);
      osc_ctrl_reg.main_freq_range <= pin_cfg_reg[clkg_pkg::RANGE_BIT];
    end
  end

  // Standby gating and timer count clock choice.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      periph_sub_en_reg <= 1'b1;
      timer_slow_reg <= 1'b0;
    end else begin
      periph_sub_en_reg <= !(standby_active && cpu_stat_reg
        && supply_reg[clkg_pkg::SUB_GATE_BIT]);
      timer_slow_reg <= supply_reg[clkg_pkg::TIMER_SEL_BIT];
    end
  end

  localparam int SETTLE_BOUND = 8;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_main_pin_mode: assert property (
    !pin_cfg_reg[clkg_pkg::MAIN_OSC_BIT] |=> osc_ctrl_reg.main_mode == clkg_pkg::PIN_PORT)
    else $error("Main pins left port mode while the pin field selects port.");
  a_sub_pin_mode: assert property (
    pin_cfg_reg[clkg_pkg::SUB_EXT_BIT] && pin_cfg_reg[clkg_pkg::SUB_OSC_BIT]
    |=> osc_ctrl_reg.sub_mode == clkg_pkg::PIN_EXTERNAL)
    else $error("Subsystem pins not in external clock mode for field 11.");
  a_drive_legal: assert property (
    osc_ctrl_reg.sub_drive != clkg_pkg::DRIVE_PROHIBITED)
    else $error("Prohibited subsystem drive code reached the oscillator.");
  a_freq_range: assert property (
    osc_ctrl_reg.main_freq_range == $past(pin_cfg_reg[clkg_pkg::RANGE_BIT]))
    else $error("Main frequency range does not follow its register bit.");
  a_main_halt: assert property (
    osc_ctrl_reg.main_run |-> osc_ctrl_reg.main_mode != clkg_pkg::PIN_PORT
    && !$past(run_ctl_reg[clkg_pkg::MAIN_HALT_BIT]))
    else $error("Main oscillator runs while halted or in port mode.");
  a_sub_halt: assert property (
    $past(run_ctl_reg[clkg_pkg::SUB_HALT_BIT]) |-> !osc_ctrl_reg.sub_run)
    else $error("Subsystem oscillator runs while halted.");
  a_fast_halt: assert property (
    $past(hresetn) |-> osc_ctrl_reg.fast_run != $past(run_ctl_reg[clkg_pkg::FAST_HALT_BIT]))
    else $error("Internal fast oscillator run does not follow its halt bit.");
  a_cpu_status_cause: assert property (
    $changed(cpu_stat_reg) |-> cpu_stat_reg == $past(cpu_want) && $past(sw_state_reg == SW_SETTLE))
    else $error("CPU clock status moved without a completed switch.");
  a_cpu_sub_ready: assert property (
    $rose(cpu_stat_reg) |-> $past(sub_ready, 2))
    else $error("CPU switched to subsystem clock that was not ready.");
  a_main_status: assert property (
    $changed(main_stat_reg) |-> $past(sw_is_main_reg) && $past(sw_count_reg) == 3'h0)
    else $error("Main clock status moved outside the settle end.");
  a_main_ext_ready: assert property (
    $rose(main_stat_reg) |-> $past(main_ext_ready, 2))
    else $error("Main clock switched to external source that was not ready.");
  a_switch_bounded: assert property (
    $rose(sw_state_reg == SW_SETTLE) |-> ##[1:SETTLE_BOUND] sw_state_reg == SW_IDLE)
    else $error("Clock switch did not finish within the settle bound.");
  a_standby_gate: assert property (
    standby_active && cpu_stat_reg && supply_reg[clkg_pkg::SUB_GATE_BIT]
    |=> !periph_sub_en_reg)
    else $error("Subsystem clock to peripherals not gated in standby.");
  a_timer_clock: assert property (
    $changed(supply_reg[clkg_pkg::TIMER_SEL_BIT]) |=> timer_slow_reg == $past(supply_reg[clkg_pkg::TIMER_SEL_BIT]))
    else $error("Timer count clock choice does not follow its bit.");
  a_reserved_zero: assert property (
    hrdata_reg[31:8] == 24'h000000 && (pin_cfg_reg & ~clkg_pkg::PIN_CFG_MASK) == 8'h00)
    else $error("Unused bits read as non-zero.");
  a_drive_refused: assert property (
    wr_pend_reg && (wr_addr_reg == clkg_pkg::ADDR_PIN_CFG)
    && (hwdata[clkg_pkg::DRIVE_HI_BIT:clkg_pkg::DRIVE_LO_BIT] == 2'h3)
    |=> $stable(pin_cfg_reg[clkg_pkg::DRIVE_HI_BIT:clkg_pkg::DRIVE_LO_BIT]))
    else $error("Prohibited drive code was stored.");
  a_unmapped_read: assert property (
    addr_accept && !hwrite && (haddr[31:clkg_pkg::ADDR_W] != 28'h0000000)
    |=> hrdata_reg == 32'h00000000)
    else $error("Unmapped read returned non-zero data.");
  a_periph_awake: assert property (
    !standby_active |=> periph_sub_en_reg)
    else $error("Subsystem clock to peripherals gated outside standby.");
  a_reserved_regs: assert property (
    (run_ctl_reg & ~clkg_pkg::RUN_CTL_MASK) == 8'h00 && (supply_reg & ~clkg_pkg::SUPPLY_MASK) == 8'h00
    && (sys_sel_reg & ~clkg_pkg::SYS_SEL_MASK) == 8'h00)
    else $error("Unused register bits hold non-zero values.");
  a_sub_port_idle: assert property (
    osc_ctrl_reg.sub_mode == clkg_pkg::PIN_PORT |-> !osc_ctrl_reg.sub_run)
    else $error("Subsystem oscillator runs while its pins are in port mode.");

  // Covers for the main switching, refusal and standby scenarios.

  c_cpu_to_sub: cover property ($rose(cpu_stat_reg));
  c_main_to_ext: cover property ($rose(main_stat_reg));
  c_switch_abort: cover property (sw_state_reg == SW_SETTLE ##1 sw_state_reg == SW_IDLE
    && sw_count_reg != 3'h0);
  c_standby_gated: cover property ($fell(periph_sub_en_reg));
  c_drive_refused: cover property (wr_pend_reg && (wr_addr_reg == clkg_pkg::ADDR_PIN_CFG)
    && (hwdata[clkg_pkg::DRIVE_HI_BIT:clkg_pkg::DRIVE_LO_BIT] == 2'h3));
endmodule : clkg_top
`default_nettype wire
